// ---- rpm_ctrl.sv ----
// Reset pulses, idle and power-down control with AXI4-Lite registers
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rpm_defs.svh"

module rpm_ctrl #(
    parameter int unsigned STARTUP_CYC = `RPM_SUT_CYC
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  sys_rst_i,
    // Register bus
    input  wire rpm_pkg::rpm_axi_req_t axi_req_i,
    output rpm_pkg::rpm_axi_rsp_t      axi_rsp_o,
    // Events from on-chip logic
    input  wire logic                  wdt_timeout_i,
    input  wire logic                  irq_pending_i,
    input  wire logic                  frame_error_i,
    input  wire logic                  serial_mode_bit0_i,
    // Pins and power-on detector
    input  wire logic                  ext_irq_zero_n_i,
    input  wire logic                  ext_irq_one_n_i,
    input  wire logic                  general_irq_three_n_i,
    input  wire logic                  reset_pin_n_i,
    input  wire logic                  power_on_i,
    // Reset and clock control
    output logic                       internal_rst_o,
    output logic                       cpu_clk_en_o,
    output logic                       osc_en_o,
    output logic                       brownout_en_o,
    output logic                       flash_pwr_en_o,
    // Peripheral control
    output logic                       port_hold_o,
    output logic                       periph_run_o,
    output logic                       wdt_run_o,
    output logic                       cmp_run_o,
    output logic                       watchdog_kick_o,
    output logic                       baud_doubler_o,
    output logic                       frame_error_select_o
);

    localparam int NPIN = 5;
    localparam logic [NPIN-1:0] PIN_IDLE = 5'h0f;
    localparam logic [15:0] SUT_LOAD = 16'(STARTUP_CYC - 1);

    // Pin synchroniser: value changes once stages two and three agree
    logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q, pin_d, prev_q;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1_q   <= PIN_IDLE;
            s2_q   <= PIN_IDLE;
            s3_q   <= PIN_IDLE;
            pin_q  <= PIN_IDLE;
            prev_q <= PIN_IDLE;
        end else begin
            s1_q   <= {power_on_i, reset_pin_n_i, general_irq_three_n_i,
                       ext_irq_one_n_i, ext_irq_zero_n_i};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            pin_q  <= pin_d;
            prev_q <= pin_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            always_comb begin
                pin_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : pin_q[gi];
            end
        end
    endgenerate

    // Register index decode, used by both bus directions
    function automatic logic idx_hit(input logic [11:0] a);
        logic [7:0] ix;
        ix = a[9:2];
        return (a[11:10] == 2'h0) && (ix >= `RPM_IDX_PWR) &&
               (ix <= `RPM_IDX_STS);
    endfunction

    // Control state
    rpm_pkg::rpm_state_t st_q, st_d;
    logic [7:0]  power_control_q, power_control_d;
    logic [6:0]  wake_q, wake_d;
    logic        wdf_q, wdf_d, swf_q, swf_d, fe_q, fe_d;
    logic        wdi_q, wdi_d, cmi_q, cmi_d;
    logic        arm_k_q, arm_k_d, arm_s_q, arm_s_d, kick_q, kick_d;
    logic [4:0]  rcnt_q, rcnt_d;
    logic [15:0] tmr_q, tmr_d;
    logic        rst_q, rst_d, clk_q, clk_d;
    logic        we;
    logic [7:0]  widx, wdat;

    // Bus state
    logic        awg_q, awg_d, wg_q, wg_d, bv_q, bv_d, rv_q, rv_d;
    logic [11:0] awa_q, awa_d;
    logic [7:0]  wd_q, wd_d;
    logic        ws_q, ws_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    logic [31:0] rd_q, rd_d;

    // Pin aliases and wake qualification
    logic e0, e1, g3, rp, pwr_on, wake_fall, wake_low, rst_fall, in_run;
    always_comb begin
        e0 = wake_q[`RPM_WK_EN0] & wake_q[`RPM_WK_LVL0];
        e1 = wake_q[`RPM_WK_EN1] & wake_q[`RPM_WK_LVL1];
        g3 = wake_q[`RPM_WK_EN3] & wake_q[`RPM_WK_LOW3] &
             ~wake_q[`RPM_WK_RSTEN];
        rp = wake_q[`RPM_WK_RSTEN];
        pwr_on = pin_q[4];
        wake_fall = (e0 & prev_q[0] & ~pin_q[0]) |
                    (e1 & prev_q[1] & ~pin_q[1]) |
                    (g3 & prev_q[2] & ~pin_q[2]);
        wake_low  = (e0 & ~pin_q[0]) | (e1 & ~pin_q[1]) | (g3 & ~pin_q[2]);
        rst_fall  = rp & prev_q[3] & ~pin_q[3];
        in_run    = (st_q == rpm_pkg::ST_RUN) || (st_q == rpm_pkg::ST_IDLE);
    end

    // Register writes, reset pulses and power state machine
    always_comb begin
        st_d = st_q;
        power_control_d = power_control_q;
        wake_d = wake_q;
        wdf_d = wdf_q;
        swf_d = swf_q;
        fe_d = fe_q;
        wdi_d = wdi_q;
        cmi_d = cmi_q;
        arm_k_d = arm_k_q;
        arm_s_d = arm_s_q;
        kick_d = 1'b0;
        rcnt_d = (rcnt_q != 5'h00) ? rcnt_q - 5'h01 : 5'h00;
        tmr_d = tmr_q;
        if (we) begin
            unique case (widx)
                `RPM_IDX_PWR: power_control_d = wdat;
                `RPM_IDX_WDC: begin
                    wdf_d = wdf_q & ~wdat[0];
                    swf_d = swf_q & ~wdat[1];
                    wdi_d = wdat[2];
                    cmi_d = wdat[3];
                end
                `RPM_IDX_WDR: begin
                    kick_d  = arm_k_q && (wdat == `RPM_KICK_B);
                    arm_k_d = (wdat == `RPM_KICK_A);
                end
                `RPM_IDX_SWR: begin
                    if (arm_s_q && (wdat == `RPM_SWR_B)) begin
                        rcnt_d = `RPM_WD_RST_CYC;
                        swf_d = 1'b1;
                    end
                    arm_s_d = (wdat == `RPM_SWR_A);
                end
                `RPM_IDX_WAK: wake_d = wdat[6:0];
                `RPM_IDX_SER: fe_d = fe_q & ~(wdat[7] & power_control_q[`RPM_PC_FSEL]);
                default: ;
            endcase
        end
        // frame error sets whatever the view; set beats clear
        if (frame_error_i) fe_d = 1'b1;
        if (wdt_timeout_i) begin
            rcnt_d = `RPM_WD_RST_CYC;
            wdf_d = 1'b1;
        end
        if (pwr_on) power_control_d[`RPM_PC_OFF] = 1'b1;
        unique case (st_q)
            rpm_pkg::ST_RUN: begin
                if (power_control_q[`RPM_PC_PWRDN]) st_d = rpm_pkg::ST_PWRDN;
                else if (power_control_q[`RPM_PC_IDLE]) st_d = rpm_pkg::ST_IDLE;
            end
            rpm_pkg::ST_IDLE: begin
                if (irq_pending_i) begin
                    st_d = rpm_pkg::ST_RUN;
                    power_control_d[`RPM_PC_IDLE] = 1'b0;
                end
            end
            rpm_pkg::ST_PWRDN: begin
                if (wake_fall) begin
                    tmr_d = SUT_LOAD;
                    st_d = power_control_q[`RPM_PC_EXIT] ? rpm_pkg::ST_WAKE_EXT
                                                : rpm_pkg::ST_WAKE_TIMED;
                end else if (rst_fall) begin
                    tmr_d = SUT_LOAD;
                    st_d = rpm_pkg::ST_RST_WAKE;
                end
            end
            rpm_pkg::ST_WAKE_TIMED: begin
                // pin may rise early, timer alone decides
                if (tmr_q == 16'h0000) begin
                    st_d = rpm_pkg::ST_RUN;
                    power_control_d[`RPM_PC_PWRDN] = 1'b0;
                    power_control_d[`RPM_PC_IDLE] = 1'b0;
                end else begin
                    tmr_d = tmr_q - 16'h0001;
                end
            end
            rpm_pkg::ST_WAKE_EXT: begin
                if (!wake_low) begin
                    st_d = rpm_pkg::ST_RUN;
                    power_control_d[`RPM_PC_PWRDN] = 1'b0;
                    power_control_d[`RPM_PC_IDLE] = 1'b0;
                end
            end
            rpm_pkg::ST_RST_WAKE: begin
                if (tmr_q == 16'h0000) begin
                    if (pin_q[3]) begin
                        st_d = rpm_pkg::ST_RUN;
                        rcnt_d = `RPM_PIN_RST_CYC;
                    end else begin
                        st_d = rpm_pkg::ST_RST_HOLD;
                    end
                    power_control_d[`RPM_PC_PWRDN] = 1'b0;
                    power_control_d[`RPM_PC_IDLE] = 1'b0;
                end else begin
                    tmr_d = tmr_q - 16'h0001;
                end
            end
            rpm_pkg::ST_RST_HOLD: begin
                // stay in reset until the pin is high
                if (pin_q[3]) st_d = rpm_pkg::ST_RUN;
            end
            // Unused state code falls back to run
            default: st_d = rpm_pkg::ST_RUN;
        endcase
        // reset ends idle; warm reset keeps power-off flag
        if (rst_q && in_run) begin
            st_d = rpm_pkg::ST_RUN;
            power_control_d = power_control_d & (8'h01 << `RPM_PC_OFF);
            arm_k_d = 1'b0;
            arm_s_d = 1'b0;
        end
        rst_d = (rcnt_d != 5'h00) || (st_d == rpm_pkg::ST_RST_HOLD) ||
                (rp && !pin_q[3] && in_run);
        clk_d = (st_d == rpm_pkg::ST_RUN);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q <= rpm_pkg::ST_RUN;
            power_control_q <= `RPM_PC_RST;
            wake_q <= `RPM_WK_RST;
            {wdf_q, swf_q, fe_q, wdi_q, cmi_q} <= 5'h00;
            {arm_k_q, arm_s_q, kick_q} <= 3'h0;
            rcnt_q <= 5'h00;
            tmr_q <= 16'h0000;
            rst_q <= 1'b0;
            clk_q <= 1'b1;
        end else begin
            st_q <= st_d;
            power_control_q <= power_control_d;
            wake_q <= wake_d;
            {wdf_q, swf_q, fe_q, wdi_q, cmi_q} <=
                {wdf_d, swf_d, fe_d, wdi_d, cmi_d};
            {arm_k_q, arm_s_q, kick_q} <= {arm_k_d, arm_s_d, kick_d};
            rcnt_q <= rcnt_d;
            tmr_q <= tmr_d;
            rst_q <= rst_d;
            clk_q <= clk_d;
        end
    end

    // Read view of one register
    function automatic logic [7:0] rd_val(input logic [7:0] ix);
        unique case (ix)
            `RPM_IDX_PWR: return power_control_q;
            `RPM_IDX_WDC: return {4'h0, cmi_q, wdi_q, swf_q, wdf_q};
            `RPM_IDX_WAK: return {1'b0, wake_q};
            // bit 7 view by frame error select
            `RPM_IDX_SER: return {power_control_q[`RPM_PC_FSEL] ? fe_q
                                  : serial_mode_bit0_i, 7'h00};
            `RPM_IDX_STS: return {4'h0, rst_q, st_q == rpm_pkg::ST_PWRDN,
                                  st_q == rpm_pkg::ST_IDLE, clk_q};
            default: return 8'h00;
        endcase
    endfunction

    // AXI4-Lite slave; address and data latched in either order
    always_comb begin
        awg_d = awg_q;
        wg_d = wg_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q & ~axi_req_i.bready;
        br_d = br_q;
        rv_d = rv_q & ~axi_req_i.rready;
        rr_d = rr_q;
        rd_d = rd_q;
        axi_rsp_o.awready = !awg_q && !bv_q;
        axi_rsp_o.wready = !wg_q && !bv_q;
        axi_rsp_o.arready = !rv_q;
        if (axi_req_i.awvalid && axi_rsp_o.awready) begin
            awg_d = 1'b1;
            awa_d = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && axi_rsp_o.wready) begin
            wg_d = 1'b1;
            wd_d = axi_req_i.wdata[7:0];
            ws_d = axi_req_i.wstrb[0];
        end
        // Write lands one cycle after both halves are held
        we = awg_q && wg_q && idx_hit(awa_q) && ws_q;
        widx = awa_q[9:2];
        wdat = wd_q;
        if (awg_q && wg_q) begin
            awg_d = 1'b0;
            wg_d = 1'b0;
            bv_d = 1'b1;
            br_d = idx_hit(awa_q) ? `RPM_RESP_OK : `RPM_RESP_ERR;
        end
        if (axi_req_i.arvalid && axi_rsp_o.arready) begin
            rv_d = 1'b1;
            rr_d = idx_hit(axi_req_i.araddr) ? `RPM_RESP_OK : `RPM_RESP_ERR;
            // Refused reads return zero data
            rd_d = idx_hit(axi_req_i.araddr)
                 ? {24'h000000, rd_val(axi_req_i.araddr[9:2])}
                 : 32'h00000000;
        end
        axi_rsp_o.bvalid = bv_q;
        axi_rsp_o.bresp = br_q;
        axi_rsp_o.rvalid = rv_q;
        axi_rsp_o.rresp = rr_q;
        axi_rsp_o.rdata = rd_q;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            {awg_q, wg_q, bv_q, rv_q, ws_q} <= 5'h00;
            awa_q <= 12'h000;
            wd_q <= 8'h00;
            br_q <= 2'h0;
            rr_q <= 2'h0;
            rd_q <= 32'h00000000;
        end else begin
            {awg_q, wg_q, bv_q, rv_q, ws_q} <= {awg_d, wg_d, bv_d, rv_d, ws_d};
            awa_q <= awa_d;
            wd_q <= wd_d;
            br_q <= br_d;
            rr_q <= rr_d;
            rd_q <= rd_d;
        end
    end

    // Outputs; power and hold enables decoded from state
    always_comb begin
        internal_rst_o = rst_q;
        cpu_clk_en_o = clk_q;
        osc_en_o = (st_q != rpm_pkg::ST_PWRDN);
        brownout_en_o = (st_q != rpm_pkg::ST_PWRDN);
        flash_pwr_en_o = (st_q != rpm_pkg::ST_PWRDN);
        // ports frozen, peripherals alive in idle
        port_hold_o = (st_q == rpm_pkg::ST_IDLE);
        periph_run_o = in_run;
        wdt_run_o = (st_q == rpm_pkg::ST_RUN) || (port_hold_o && wdi_q);
        cmp_run_o = (st_q == rpm_pkg::ST_RUN) || (port_hold_o && cmi_q);
        watchdog_kick_o = kick_q;
        baud_doubler_o = power_control_q[`RPM_PC_BAUD];
        frame_error_select_o = power_control_q[`RPM_PC_FSEL];
    end

endmodule

// ---- rpm_defs.svh ----
// Offsets, field positions, reset values and timing counts for rpm block
`ifndef RPM_DEFS_SVH
`define RPM_DEFS_SVH

// Register indices; byte address is four times the index
`define RPM_IDX_PWR      8'h87
`define RPM_IDX_WDC      8'h88
`define RPM_IDX_WDR      8'h89
`define RPM_IDX_SWR      8'h8a
`define RPM_IDX_WAK      8'h8b
`define RPM_IDX_SER      8'h8c
`define RPM_IDX_STS      8'h8d

// Power control fields
`define RPM_PC_IDLE      0
`define RPM_PC_PWRDN     1
`define RPM_PC_OFF       4
`define RPM_PC_EXIT      5
`define RPM_PC_FSEL      6
`define RPM_PC_BAUD      7
`define RPM_PC_RST       8'h00

// Wake configuration fields
`define RPM_WK_EN0       0
`define RPM_WK_EN1       1
`define RPM_WK_LVL0      2
`define RPM_WK_LVL1      3
`define RPM_WK_EN3       4
`define RPM_WK_LOW3      5
`define RPM_WK_RSTEN     6
`define RPM_WK_RST       7'h40

// Unlock sequences
`define RPM_KICK_A       8'h1e
`define RPM_KICK_B       8'he1
`define RPM_SWR_A        8'h5a
`define RPM_SWR_B        8'ha5

// Timing
`define RPM_CLK_MHZ      40
`define RPM_SUT_US       16
`define RPM_SUT_CYC      (`RPM_SUT_US * `RPM_CLK_MHZ)
`define RPM_WD_RST_CYC   5'h10
`define RPM_PIN_RST_CYC  5'h02

// Bus answers
`define RPM_RESP_OK      2'h0
`define RPM_RESP_ERR     2'h2

`endif

// ---- rpm_pkg.sv ----
// Types shared by the reset and power mode control block
package rpm_pkg;

    typedef enum logic [2:0] {
        ST_RUN, ST_IDLE, ST_PWRDN, ST_WAKE_TIMED, ST_WAKE_EXT,
        ST_RST_WAKE, ST_RST_HOLD
    } rpm_state_t;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } rpm_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rpm_axi_rsp_t;

endpackage

// ---- rpm_ctrl_assertions.sv ----
// Concurrent checks on the reset and power mode control ports
`timescale 1ns/1ps
module rpm_ctrl_assertions #(
    parameter int unsigned STARTUP_CYC = 640
) (
    // Clock, reset and inputs
    input wire logic                  clk_i,
    input wire logic                  sys_rst_i,
    input wire rpm_pkg::rpm_axi_req_t axi_req_i,
    input wire logic                  wdt_timeout_i,
    input wire logic                  irq_pending_i,
    input wire logic                  ext_irq_zero_n_i,
    input wire logic                  ext_irq_one_n_i,
    input wire logic                  general_irq_three_n_i,
    input wire logic                  reset_pin_n_i,
    input wire logic                  power_on_i,
    // Outputs watched
    input wire rpm_pkg::rpm_axi_rsp_t axi_rsp_o,
    input wire logic                  internal_rst_o,
    input wire logic                  cpu_clk_en_o,
    input wire logic                  osc_en_o,
    input wire logic                  brownout_en_o,
    input wire logic                  flash_pwr_en_o,
    input wire logic                  port_hold_o,
    input wire logic                  periph_run_o,
    input wire logic                  watchdog_kick_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [3:0] quiet_d, quiet_q;
    logic       pin_act;
    // Any wake source active; power-on counts as one
    assign pin_act = !(ext_irq_zero_n_i && ext_irq_one_n_i &&
        general_irq_three_n_i && reset_pin_n_i) || power_on_i;
    // Cycles since a wake source was active, saturating
    always_comb begin
        quiet_d = quiet_q;
        if (sys_rst_i || (!pin_act && quiet_q != 4'hf))
            quiet_d = sys_rst_i ? 4'hf : quiet_q + 4'h1;
        else if (pin_act)
            quiet_d = 4'h0;
    end
    always_ff @(posedge clk_i) begin
        quiet_q <= quiet_d;
    end
    a_wdt_rst_len: assert property (
        wdt_timeout_i && cpu_clk_en_o && !internal_rst_o |->
        ##1 internal_rst_o[*8] ##1 internal_rst_o[*8] ##1 !internal_rst_o)
        else $error("watchdog reset pulse not 16 cycles");
    a_idle_state: assert property (
        $rose(port_hold_o) |-> !cpu_clk_en_o && periph_run_o && osc_en_o)
        else $error("idle entry outputs wrong");
    a_pd_state: assert property (
        !osc_en_o |-> !cpu_clk_en_o && !brownout_en_o && !flash_pwr_en_o
        && !periph_run_o)
        else $error("power-down outputs wrong");
    a_idle_exit: assert property (
        port_hold_o && irq_pending_i |-> ##[1:3] (!port_hold_o && cpu_clk_en_o))
        else $error("idle not ended by interrupt");
    a_pd_wake_src: assert property (
        $rose(osc_en_o) |-> quiet_q < 4'hc)
        else $error("power-down left without wake source");
    a_wake_gated: assert property (
        $rose(osc_en_o) |-> !cpu_clk_en_o ##1 !cpu_clk_en_o)
        else $error("cpu clock not gated at wake");
    a_kick_single: assert property (
        watchdog_kick_o |=> !watchdog_kick_o)
        else $error("watchdog restart pulse too long");
    a_read_lat: assert property (
        axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
        else $error("read answer late");
    c_idle: cover property ($rose(port_hold_o));
    c_pd: cover property ($fell(osc_en_o));
    c_kick: cover property (watchdog_kick_o);
endmodule

bind rpm_ctrl rpm_ctrl_assertions #(.STARTUP_CYC(STARTUP_CYC))
    i_rpm_ctrl_assertions (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .axi_req_i(axi_req_i), .wdt_timeout_i(wdt_timeout_i),
    .irq_pending_i(irq_pending_i), .ext_irq_zero_n_i(ext_irq_zero_n_i),
    .ext_irq_one_n_i(ext_irq_one_n_i), .reset_pin_n_i(reset_pin_n_i),
    .general_irq_three_n_i(general_irq_three_n_i), .power_on_i(power_on_i),
    .axi_rsp_o(axi_rsp_o), .internal_rst_o(internal_rst_o),
    .cpu_clk_en_o(cpu_clk_en_o), .osc_en_o(osc_en_o),
    .brownout_en_o(brownout_en_o), .flash_pwr_en_o(flash_pwr_en_o),
    .port_hold_o(port_hold_o), .periph_run_o(periph_run_o),
    .watchdog_kick_o(watchdog_kick_o));

// ---- rpm_pins.sv ----
// Pin-side model: pulls wake and reset pins low on request
`timescale 1ns/1ps
module rpm_pins (
    // Clock and request from the bench
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [1:0] sel_i,
    input  wire logic [7:0] low_i,
    // Pins: 0 ext0, 1 ext1, 2 irq3, 3 reset
    output logic      [3:0] pin_n_o
);
    logic [7:0] left_q = 8'h00;
    logic [1:0] who_q = 2'h0;
    always @(posedge clk_i) begin
        if (go_i) begin
            left_q <= low_i;
            who_q  <= sel_i;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
    // Released pins sit at their pull-up level
    always_comb begin
        pin_n_o = 4'hf;
        if (left_q != 8'h00)
            pin_n_o[who_q] = 1'b0;
    end
endmodule

// ---- tb_rpm_ctrl.sv ----
// Self-checking bench for the reset and power mode control block
`timescale 1ns/1ps
`include "rpm_defs.svh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
    err_total++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb_rpm_ctrl;
    typedef struct {logic [7:0] d; logic [7:0] m; logic [1:0] r;} rpm_exp_t;
    localparam logic [7:0] PWR = `RPM_IDX_PWR;
    localparam logic [7:0] WDC = `RPM_IDX_WDC;
    localparam logic [7:0] WAK = `RPM_IDX_WAK;
    localparam logic [7:0] SER = `RPM_IDX_SER;
    logic                  clk_i = 1'b0;
    logic                  sys_rst_i = 1'b1;
    rpm_pkg::rpm_axi_req_t req = '0;
    rpm_pkg::rpm_axi_rsp_t rsp;
    logic wto = 0, irq = 0, fe = 0, smb = 0, pon = 0, go = 0;
    logic [1:0] sel = 0;
    logic [7:0] low = 0;
    logic [3:0] pin;
    logic rst, cen, osc, brownout_detector, fl, hold, prun, wrun, crun, kick, baud, fsel;
    int err_total = 0, checks_done = 0, kicks = 0, rlen = 0;
    rpm_exp_t rd_q[$];
    int rst_q[$];
    rpm_ctrl #(.STARTUP_CYC(8)) i_rpm_ctrl (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .axi_req_i(req), .axi_rsp_o(rsp),
        .wdt_timeout_i(wto), .irq_pending_i(irq), .frame_error_i(fe),
        .serial_mode_bit0_i(smb), .ext_irq_zero_n_i(pin[0]),
        .ext_irq_one_n_i(pin[1]), .general_irq_three_n_i(pin[2]),
        .reset_pin_n_i(pin[3]), .power_on_i(pon), .internal_rst_o(rst),
        .cpu_clk_en_o(cen), .osc_en_o(osc), .brownout_en_o(brownout_detector),
        .flash_pwr_en_o(fl), .port_hold_o(hold), .periph_run_o(prun),
        .wdt_run_o(wrun), .cmp_run_o(crun), .watchdog_kick_o(kick),
        .baud_doubler_o(baud), .frame_error_select_o(fsel));
    rpm_pins i_rpm_pins (.clk_i(clk_i), .go_i(go), .sel_i(sel),
        .low_i(low), .pin_n_o(pin));
    // 40 MHz clock
    initial forever #12.5 clk_i = ~clk_i;
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge clk_i);
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.awaddr <= ad(i);
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!(rsp.bvalid && req.bready));
        req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] d,
        input logic [7:0] m = 8'hff, input logic [1:0] r = `RPM_RESP_OK);
        rd_q.push_back('{d & m, m, r});
        @(posedge clk_i);
        req.arvalid <= 1'b1;
        req.araddr <= ad(i);
        req.rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!(rsp.rvalid && req.rready));
        req.rready <= 1'b0;
    endtask
    task automatic pulse(input logic [1:0] s, input logic [7:0] n);
        @(posedge clk_i);
        go <= 1'b1;
        sel <= s;
        low <= n;
        @(posedge clk_i);
        go <= 1'b0;
    endtask
    task automatic wait_clk(output int n);
        n = 0;
        while (cen !== 1'b1 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Monitor: reads, reset pulse lengths and restart pulses
    always @(posedge clk_i) begin
        rpm_exp_t e;
        if (rsp.rvalid && req.rready && rd_q.size() > 0) begin
            e = rd_q.pop_front();
            `CHK("rdata", e.d, rsp.rdata[7:0] & e.m)
            `CHK("rresp", e.r, rsp.rresp)
        end
        // Every bench write targets a mapped register
        if (rsp.bvalid && req.bready)
            `CHK("bresp", `RPM_RESP_OK, rsp.bresp)
        if (rst === 1'b1)
            rlen++;
        else if (rlen > 0) begin
            `CHK("rst_len", rst_q.pop_front(), rlen)
            rlen = 0;
        end
        if (kick === 1'b1)
            kicks++;
    end
    // Watchdog on a hung run
    initial begin
        repeat (8000) @(posedge clk_i);
        err_total++;
        summarize();
    end
    // Main sequence
    initial begin
        int c;
        logic [7:0] g;
        c = $urandom(52920);
        g = 8'($urandom) & 8'h0c;
        smb <= 1'($urandom);
        tick(1);
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(PWR, `RPM_PC_RST);
        rd(WAK, {1'b0, `RPM_WK_RST});
        rd(8'h00, 8'h00, 8'hff, `RPM_RESP_ERR);
        $display("test regs done");
        @(posedge clk_i);
        pon <= 1'b1;
        tick(8);
        @(posedge clk_i);
        pon <= 1'b0;
        rd(PWR, 8'h10);
        wr(PWR, 8'hd0 | g);
        rd(PWR, 8'hd0 | g);
        tick(1);
        `CHK("baud", 1'b1, baud)
        `CHK("fsel", 1'b1, fsel)
        rd(SER, 8'h00, 8'h80);
        @(posedge clk_i);
        fe <= 1'b1;
        @(posedge clk_i);
        fe <= 1'b0;
        rd(SER, 8'h80, 8'h80);
        $display("test power_control done");
        rst_q.push_back(16);
        @(posedge clk_i);
        wto <= 1'b1;
        @(posedge clk_i);
        wto <= 1'b0;
        tick(24);
        rd(WDC, 8'h01, 8'h03);
        rd(PWR, 8'h10);
        rd(SER, {smb, 7'h00}, 8'h80);
        wr(WDC, 8'h03);
        rst_q.push_back(16);
        wr(`RPM_IDX_SWR, `RPM_SWR_A);
        wr(`RPM_IDX_SWR, `RPM_SWR_B);
        tick(24);
        rd(WDC, 8'h02, 8'h03);
        c = kicks;
        wr(`RPM_IDX_WDR, `RPM_KICK_A);
        wr(`RPM_IDX_WDR, 8'h00);
        wr(`RPM_IDX_WDR, `RPM_KICK_B);
        wr(`RPM_IDX_WDR, `RPM_KICK_A);
        wr(`RPM_IDX_WDR, `RPM_KICK_B);
        tick(4);
        `CHK("kicks", c + 1, kicks)
        $display("test resets done");
        for (int i = 0; i < 2; i++) begin
            wr(WDC, (i == 1) ? 8'h0c : 8'h00);
            wr(PWR, 8'h01);
            tick(3);
            `CHK("cpu_clk", 1'b0, cen)
            `CHK("hold", 1'b1, hold)
            `CHK("periph", 1'b1, prun)
            `CHK("wdt_run", 1'(i), wrun)
            `CHK("cmp_run", 1'(i), crun)
            rd(`RPM_IDX_STS, 8'h02);
            @(posedge clk_i);
            irq <= 1'b1;
            tick(3);
            `CHK("cpu_clk", 1'b1, cen)
            @(posedge clk_i);
            irq <= 1'b0;
            rd(PWR, 8'h00, 8'h01);
        end
        $display("test idle done");
        wr(WAK, 8'h05);
        wr(PWR, 8'h02);
        tick(3);
        `CHK("osc", 1'b0, osc)
        `CHK("bod", 1'b0, brownout_detector)
        `CHK("flash", 1'b0, fl)
        pulse(2'd1, 8'd10);
        tick(20);
        `CHK("osc", 1'b0, osc)
        pulse(2'd0, 8'd6);
        wait_clk(c);
        `CHK("timed", 1'b1, c >= 8 && c < 30)
        rd(PWR, 8'h00, 8'h03);
        wr(WAK, 8'h0a);
        wr(PWR, 8'h22);
        pulse(2'd1, 8'd40);
        tick(20);
        `CHK("osc", 1'b1, osc)
        `CHK("cpu_clk", 1'b0, cen)
        wait_clk(c);
        `CHK("ext", 1'b1, c >= 15 && c < 40)
        rd(PWR, 8'h20);
        wr(PWR, 8'h03);
        tick(3);
        `CHK("hold", 1'b0, hold)
        `CHK("osc", 1'b0, osc)
        pulse(2'd1, 8'd10);
        wait_clk(c);
        `CHK("both", 1'b1, c >= 8 && c < 30)
        rd(PWR, 8'h00);
        $display("test powerdown done");
        wr(WAK, 8'h70);
        wr(PWR, 8'h02);
        pulse(2'd2, 8'd10);
        tick(30);
        `CHK("osc", 1'b0, osc)
        rst_q.push_back(2);
        pulse(2'd3, 8'd6);
        wait_clk(c);
        `CHK("rst_wake", 1'b1, c >= 8 && c < 30)
        tick(10);
        wr(WAK, 8'h30);
        wr(PWR, 8'h02);
        pulse(2'd2, 8'd6);
        wait_clk(c);
        `CHK("general_irq_three", 1'b1, c >= 8 && c < 30)
        $display("test wake pins done");
        tick(4);
        summarize();
    end
endmodule
